/* File: rtl/bsw_front.sv */
`timescale 1ns/100ps
module bsw_front #(
	parameter int ADDR_W = bsw_pkg::ADDR_W,
	parameter int DATA_W = bsw_pkg::DATA_W
) (
	input wire logic I_CLK_SYS,
	input wire logic I_ARST_N,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [DATA_W-1:0] I_DATA,
	input wire logic I_CHIP_SELECT_N,
	input wire logic I_CHIP_SELECT_SECONDARY_N,
	input wire logic I_PROCESSOR_ADDRESS_STROBE_N,
	input wire logic I_CONTROLLER_ADDRESS_STROBE_N,
	input wire logic I_BURST_STEP_N,
	input wire logic I_GLOBAL_WRITE_N,
	input wire logic I_BYTE_WRITE_GATE_N,
	input wire logic [3:0] I_BYTE_STROBE_N,
	input wire logic I_MODE_INTERLEAVED,
	output logic [ADDR_W-1:0] O_MEM_ADDR,
	output logic [DATA_W-1:0] O_MEM_WDATA,
	output logic [3:0] O_MEM_LANE_WE,
	output logic O_MEM_READ,
	output logic O_SELECTED,
	output logic O_DATA_OE_N,
	output logic [1:0] O_BURST_BEAT
);
	////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers
	logic [1:0] rst_sync_r;
	logic rst_n;

	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N)
			rst_sync_r <= 2'h0;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	localparam int SW = ADDR_W + DATA_W + 12;
	logic [SW-1:0] pin_meta_r, pin_r;
	logic [SW-1:0] pin_raw;

	assign pin_raw = {I_ADDR, I_DATA, I_CHIP_SELECT_N,
		I_CHIP_SELECT_SECONDARY_N, I_PROCESSOR_ADDRESS_STROBE_N,
		I_CONTROLLER_ADDRESS_STROBE_N, I_BURST_STEP_N, I_GLOBAL_WRITE_N,
		I_BYTE_WRITE_GATE_N, I_BYTE_STROBE_N, I_MODE_INTERLEAVED};

	// capture every synchronous input on the rising edge
	always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_r <= '1;
			pin_r <= '1;
		end else begin
			pin_meta_r <= pin_raw;
			pin_r <= pin_meta_r;
		end
	end

	logic [ADDR_W-1:0] s_addr;
	logic [DATA_W-1:0] s_data;
	logic s_cs_n, s_cs2_n, s_pstrobe_n, s_cstrobe_n, s_step_n;
	logic s_gwrite_n, s_bgate_n;
	logic [3:0] s_bs_n;
	logic s_mode;

	assign {s_addr, s_data, s_cs_n, s_cs2_n, s_pstrobe_n, s_cstrobe_n,
		s_step_n, s_gwrite_n, s_bgate_n, s_bs_n, s_mode} = pin_r;

	////////////////////////////////////////////////////////////////////////
	// write decode and burst counter
	logic [3:0] lane_we;
	logic any_write;

	bsw_lane_dec u_dec (
		.global_write_n(s_gwrite_n),
		.byte_write_gate_n(s_bgate_n),
		.byte_strobe_n(s_bs_n),
		.lane_we(lane_we),
		.any_write(any_write)
	);

	bsw_burst_if bif ();

	bsw_burst_cnt u_cnt (
		.clk(I_CLK_SYS),
		.rst_n(rst_n),
		.bus(bif)
	);

	////////////////////////////////////////////////////////////////////////
	// access control
	bsw_pkg::bsw_state_e state_r, state_nxt;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] wdata_r, wdata_nxt;
	logic [3:0] we_r, we_nxt;
	logic rd_r, rd_nxt, sel_r, sel_nxt, oe_n_r, oe_n_nxt;
	logic [1:0] beat_r, beat_nxt;
	logic pstrobe_go, cstrobe_go, new_sel, load, step;

	always_comb begin
		pstrobe_go = !s_pstrobe_n && !s_cs_n;
		cstrobe_go = !s_cstrobe_n;
		new_sel = !s_cs_n && !s_cs2_n;
		load = pstrobe_go || cstrobe_go;
		step = !load && !s_step_n && sel_r;
		bif.load = load;
		bif.step = step;
		bif.linear = !s_mode;
		bif.start = s_addr[1:0];
	end

	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		sel_nxt = sel_r;
		wdata_nxt = s_data;
		we_nxt = 4'h0;
		rd_nxt = 1'b0;
		oe_n_nxt = 1'b1;
		beat_nxt = bif.beat;
		if (load) begin
			sel_nxt = new_sel;
			addr_nxt = s_addr;
			beat_nxt = 2'h0;
			if (!new_sel)
				state_nxt = bsw_pkg::BSW_IDLE;
			else if (pstrobe_go || !any_write) begin
				state_nxt = bsw_pkg::BSW_READ;
				rd_nxt = 1'b1;
			end else begin
				state_nxt = bsw_pkg::BSW_WRITE;
				we_nxt = lane_we;
			end
		end else if (sel_r) begin
			// upper bits hold, low bits from the counter
			addr_nxt = {addr_r[ADDR_W-1:2], bif.low_bits};
			if (step)
				beat_nxt = bif.beat + bsw_pkg::BURST_STEP_ONE;
			if (!step && state_r != bsw_pkg::BSW_IDLE)
				state_nxt = bsw_pkg::BSW_WAIT;
			else if (any_write)
				state_nxt = bsw_pkg::BSW_WRITE;
			else
				state_nxt = bsw_pkg::BSW_READ;
			if (any_write)
				we_nxt = lane_we;
			else
				rd_nxt = 1'b1;
		end else begin
			state_nxt = bsw_pkg::BSW_IDLE;
		end
		if (sel_nxt && !s_bgate_n && (s_bs_n != 4'hF))
			oe_n_nxt = 1'b1;
		else if (sel_nxt && !s_gwrite_n)
			oe_n_nxt = 1'b1;
		else
			oe_n_nxt = !rd_nxt;
	end

	// next-cycle counter low bits differ from this cycle's when stepping
	logic [1:0] low_next;
	always_comb begin
		if (!s_mode)
			low_next = addr_r[1:0] + bsw_pkg::BURST_STEP_ONE;
		else
			low_next = addr_r[1:0] ^ (bif.beat ^ beat_nxt);
	end

	logic [ADDR_W-1:0] addr_out;
	assign addr_out = (step) ? {addr_r[ADDR_W-1:2], low_next} : addr_nxt;

	always_ff @(posedge I_CLK_SYS or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= bsw_pkg::BSW_IDLE;
			addr_r <= bsw_pkg::ADDR_RESET;
			wdata_r <= bsw_pkg::DATA_RESET;
			we_r <= 4'h0;
			rd_r <= 1'b0;
			sel_r <= 1'b0;
			oe_n_r <= 1'b1;
			beat_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_out;
			wdata_r <= wdata_nxt;
			we_r <= we_nxt;
			rd_r <= rd_nxt;
			sel_r <= sel_nxt;
			oe_n_r <= oe_n_nxt;
			beat_r <= beat_nxt;
		end
	end

	assign O_MEM_ADDR = addr_r;
	assign O_MEM_WDATA = wdata_r;
	assign O_MEM_LANE_WE = we_r;
	assign O_MEM_READ = rd_r;
	assign O_SELECTED = sel_r;
	assign O_DATA_OE_N = oe_n_r;
	assign O_BURST_BEAT = beat_r;
endmodule

/* File: include/bsw_pkg.sv */
package bsw_pkg;
	localparam int ADDR_W = 17;
	localparam int LANE_W = 9;
	localparam int LANES = 4;
	localparam int DATA_W = 36;
	localparam logic [1:0] BURST_STEP_ONE = 2'h1;
	localparam logic [1:0] BURST_LAST_BEAT = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 17'h00000;
	localparam logic [DATA_W-1:0] DATA_RESET = 36'h000000000;
	typedef enum logic [3:0] {
		BSW_IDLE = 4'h1,
		BSW_READ = 4'h2,
		BSW_WRITE = 4'h4,
		BSW_WAIT = 4'h8
	} bsw_state_e;
endpackage

/* File: include/bsw_burst_if.sv */
`timescale 1ns/100ps
interface bsw_burst_if;
	logic load;
	logic step;
	logic linear;
	logic [1:0] start;
	logic [1:0] low_bits;
	logic [1:0] beat;
	modport ctrl(output load, output step, output linear, output start,
		input low_bits, input beat);
	modport cnt(input load, input step, input linear, input start,
		output low_bits, output beat);
endinterface

/* File: rtl/bsw_burst_cnt.sv */
`timescale 1ns/100ps
module bsw_burst_cnt (
	input wire logic clk,
	input wire logic rst_n,
	bsw_burst_if.cnt bus
);
	logic [1:0] start_r, start_nxt;
	logic [1:0] beat_r, beat_nxt;
	logic [1:0] low_bits;

	always_comb begin
		start_nxt = start_r;
		beat_nxt = beat_r;
		if (bus.load) begin
			start_nxt = bus.start;
			beat_nxt = 2'h0;
		end else if (bus.step) begin
			beat_nxt = beat_r + bsw_pkg::BURST_STEP_ONE;
		end
	end

	always_comb begin
		if (bus.linear)
			low_bits = start_r + beat_r;
		else
			low_bits = start_r ^ beat_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_r <= 2'h0;
			beat_r <= 2'h0;
		end else begin
			start_r <= start_nxt;
			beat_r <= beat_nxt;
		end
	end

	assign bus.low_bits = low_bits;
	assign bus.beat = beat_r;
endmodule

/* File: rtl/bsw_lane_dec.sv */
`timescale 1ns/100ps
module bsw_lane_dec (
	input wire logic global_write_n,
	input wire logic byte_write_gate_n,
	input wire logic [3:0] byte_strobe_n,
	output logic [3:0] lane_we,
	output logic any_write
);
	always_comb begin
		for (int i = 0; i < 4; i++)
			lane_we[i] = !global_write_n ||
				(!byte_write_gate_n && !byte_strobe_n[i]);
		any_write = |lane_we;
	end
endmodule

/* File: test/bsw_front_checker.sv */
`timescale 1ns/100ps
module bsw_front_checker #(
	parameter int ADDR_W = 17,
	parameter int DATA_W = 36
) (
	input wire logic I_CLK_SYS,
	input wire logic I_ARST_N,
	input wire logic [ADDR_W-1:0] I_ADDR,
	input wire logic [DATA_W-1:0] I_DATA,
	input wire logic I_CHIP_SELECT_N,
	input wire logic I_CHIP_SELECT_SECONDARY_N,
	input wire logic I_PROCESSOR_ADDRESS_STROBE_N,
	input wire logic I_CONTROLLER_ADDRESS_STROBE_N,
	input wire logic I_BURST_STEP_N,
	input wire logic I_GLOBAL_WRITE_N,
	input wire logic I_BYTE_WRITE_GATE_N,
	input wire logic [3:0] I_BYTE_STROBE_N,
	input wire logic [ADDR_W-1:0] O_MEM_ADDR,
	input wire logic [DATA_W-1:0] O_MEM_WDATA,
	input wire logic [3:0] O_MEM_LANE_WE,
	input wire logic O_MEM_READ,
	input wire logic O_SELECTED,
	input wire logic O_DATA_OE_N,
	input wire logic [1:0] O_BURST_BEAT
);
	wire ps = !I_PROCESSOR_ADDRESS_STROBE_N & !I_CHIP_SELECT_N;
	wire cs = !I_CONTROLLER_ADDRESS_STROBE_N;
	wire pld = ps & !I_CHIP_SELECT_SECONDARY_N;
	wire dsl = (ps | cs) & (I_CHIP_SELECT_N | I_CHIP_SELECT_SECONDARY_N);
	wire hold = !ps & !cs;
	wire wr = O_MEM_LANE_WE != 4'h0;
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);
	a_load_read: assert property ($past(pld, 3) |-> O_SELECTED &&
		O_MEM_READ && O_MEM_ADDR == $past(I_ADDR, 3)) else $error("load");
	a_global_all: assert property (wr && !$past(I_GLOBAL_WRITE_N, 3)
		|-> O_MEM_LANE_WE == 4'hF) else $error("global write");
	a_lane_map: assert property (wr && $past(I_GLOBAL_WRITE_N, 3)
		|-> !$past(I_BYTE_WRITE_GATE_N, 3) &&
		O_MEM_LANE_WE == ~$past(I_BYTE_STROBE_N, 3)) else $error("lanes");
	a_wdata_take: assert property (wr
		|-> O_MEM_WDATA == $past(I_DATA, 3)) else $error("write data");
	a_oe_release: assert property ($past(!I_BYTE_WRITE_GATE_N &&
		I_BYTE_STROBE_N != 4'hF, 3) |-> O_DATA_OE_N) else $error("oe");
	a_deselect: assert property ($past(dsl, 3) |-> !O_SELECTED &&
		O_DATA_OE_N && !wr) else $error("deselect");
	a_step_beat: assert property ($past(O_SELECTED) &&
		$past(hold & !I_BURST_STEP_N, 3) |->
		O_BURST_BEAT == $past(O_BURST_BEAT) + 2'h1 &&
		O_MEM_ADDR[ADDR_W-1:2] == $past(O_MEM_ADDR[ADDR_W-1:2]))
		else $error("step");
	a_wait_hold: assert property ($past(O_SELECTED) &&
		$past(hold & I_BURST_STEP_N, 3) |-> $stable(O_MEM_ADDR))
		else $error("wait");
endmodule
bind bsw_front bsw_front_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
	u_chk (.*);

/* File: test/bsw_ctl_model.sv */
`timescale 1ns/100ps
// o_c bits: primary select, secondary select, processor strobe,
// controller strobe, burst step, global write, byte gate
module bsw_ctl_model (
	output logic [16:0] o_a,
	output logic [35:0] o_d,
	output logic [6:0] o_c,
	output logic [3:0] o_bw
);
	initial begin
		o_a = 17'h00000;
		o_d = 36'h000000000;
		o_c = 7'h7F;
		o_bw = 4'hF;
	end
	// address and data pins not used this cycle carry the inverse of their last value
	task put(input logic [16:0] na, input logic [6:0] nc,
		input logic [3:0] nb);
		o_c <= nc;
		o_bw <= nb;
		o_a <= (nc[4] & nc[3]) ? ~o_a : na;
		o_d <= (nc[1] & nc[0]) ? ~o_d : {2'h3, na, ~na};
	endtask
endmodule

/* File: test/burst_sram_write_burst_ctrl_tb.sv */
`timescale 1ns/100ps
module burst_sram_write_burst_ctrl_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic md = 1'b1;
	logic [16:0] a, ma;
	logic [35:0] d;
	logic [6:0] c;
	logic [6:0] cc[8], ew[8];
	logic [3:0] bw, we;
	logic [1:0] ea[8];
	logic [1:0] stp[8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
	logic sl, rd, oe;
	int fails = 0;
	int n_checks = 0;
	always #20 clk = ~clk;
	bsw_ctl_model u_ctl (.o_a(a), .o_d(d), .o_c(c), .o_bw(bw));
	bsw_front u_dut (.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_ADDR(a),
		.I_DATA(d), .I_CHIP_SELECT_N(c[6]), .I_CHIP_SELECT_SECONDARY_N(c[5]),
		.I_PROCESSOR_ADDRESS_STROBE_N(c[4]),
		.I_CONTROLLER_ADDRESS_STROBE_N(c[3]), .I_BURST_STEP_N(c[2]),
		.I_GLOBAL_WRITE_N(c[1]), .I_BYTE_WRITE_GATE_N(c[0]),
		.I_BYTE_STROBE_N(bw), .I_MODE_INTERLEAVED(md), .O_MEM_ADDR(ma),
		.O_MEM_WDATA(), .O_MEM_LANE_WE(we), .O_MEM_READ(rd),
		.O_SELECTED(sl), .O_DATA_OE_N(oe), .O_BURST_BEAT());
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [16:0] s, input logic [16:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: %h expected %h", $time, s, e);
		end
	endtask
	// outputs answer three edges after the pins are presented
	task run(input logic [16:0] ad, input logic [3:0] b);
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			u_ctl.put(ad, i < 8 ? cc[i] : 7'h7F, b);
			#1;
			if (i >= 3) begin
				chk(17'({sl, rd, oe, we}), 17'(ew[i-3]));
				if (sl === 1'b1) chk(ma, {ad[16:2], ea[i-3]});
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_burst(input logic m, input logic [1:0] s);
		@(posedge clk);
		md <= m;
		cc = '{7'h0F, 7'h7B, 7'h7B, 7'h7B, 7'h7F, 7'h7B, 7'h7F, 7'h7F};
		for (int k = 0; k < 8; k++) begin
			ew[k] = 7'h60;
			ea[k] = m ? s ^ stp[k] : s + stp[k];
		end
		run({15'h1A5C, s}, 4'hF);
	endtask
	// write via controller strobe, byte writes, ignored and refused loads
	task t_write;
		@(posedge clk);
		md <= 1'b0;
		cc = '{7'h15, 7'h7A, 7'h7B, 7'h7E, 7'h4F, 7'h57, 7'h2F, 7'h7F};
		ew = '{7'h5F, 7'h55, 7'h60, 7'h55, 7'h60, 7'h10, 7'h10, 7'h10};
		ea = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0};
		run(17'h0B3C5, 4'hA);
	endtask
	task final_report;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(17'({sl, rd, oe, we}), 17'h00010);
		for (int m = 0; m < 2; m++) begin
			for (int s = 0; s < 4; s++) begin
				t_burst(m[0], s[1:0]);
			end
		end
		t_write();
		final_report();
	end
endmodule
